// File: design/ccv_map.svh
// Purpose: Offsets, field positions, codes and sizes of the capture/compare control block
// Assumes: Included by bare name; definitions only
// Notes:   Byte offsets on the AXI4-Lite register bus, one aligned word each
`ifndef CCV_MAP_SVH
`define CCV_MAP_SVH

`define CCV_NCH        6
`define CCV_NSTS       8
`define CCV_AW         8
`define CCV_DW         32

`define CCV_OFF_CTL0   8'h00
`define CCV_OFF_VEC    8'h20
`define CCV_OFF_STS    8'h24
`define CCV_OFF_CLR    8'h28
`define CCV_OFF_EN     8'h2C
`define CCV_OFF_WRAP   8'h30

`define CCV_B_FLAG     0
`define CCV_B_COV      1
`define CCV_B_OUT      2
`define CCV_B_LVL      3
`define CCV_B_IE       4
`define CCV_B_MODE     5
`define CCV_B_WRAP_FL  0
`define CCV_B_WRAP_IE  1

`define CCV_STS_WRAP   6
`define CCV_STS_COV    7

`define CCV_VEC_NONE   16'h0000
`define CCV_VEC_WRAP   16'h000E

`define CCV_RESP_OKAY  2'h0
`define CCV_RESP_SLV   2'h2

`endif

// File: design/ccv_pkg.sv
// Purpose: Types shared by the capture/compare control block
// Assumes: ccv_map.svh supplies sizes
// Notes:   Nothing here is imported; users write ccv_pkg::name
`include "ccv_map.svh"
package ccv_pkg;

   typedef enum logic [2:0] {
      CCV_MODE_DIRECT     = 3'h0,
      CCV_MODE_SET        = 3'h1,
      CCV_MODE_TOG_RESET  = 3'h2,
      CCV_MODE_SET_RESET  = 3'h3,
      CCV_MODE_TOGGLE     = 3'h4,
      CCV_MODE_RESET      = 3'h5,
      CCV_MODE_TOG_SET    = 3'h6,
      CCV_MODE_RESET_SET  = 3'h7
   } ccv_mode_type;

   typedef struct packed {
      logic [`CCV_AW-1:0] awaddr;
      logic               awvalid;
      logic [`CCV_DW-1:0] wdata;
      logic [3:0]         wstrb;
      logic               wvalid;
      logic               bready;
      logic [`CCV_AW-1:0] araddr;
      logic               arvalid;
      logic               rready;
   } ccv_axi_req_type;

   typedef struct packed {
      logic               awready;
      logic               wready;
      logic [1:0]         bresp;
      logic               bvalid;
      logic               arready;
      logic [`CCV_DW-1:0] rdata;
      logic [1:0]         rresp;
      logic               rvalid;
   } ccv_axi_rsp_type;

   typedef struct packed {
      logic [`CCV_NCH-1:0] compare_hit;
      logic [`CCV_NCH-1:0] capture_hit;
      logic [`CCV_NCH-1:0] channel_input;
      logic                period_hit;
      logic                counter_wrap;
   } ccv_event_type;

   typedef struct packed {
      ccv_axi_rsp_type             rsp;
      logic [`CCV_AW-1:0]          awaddr;
      logic                        aw_full;
      logic [`CCV_DW-1:0]          wdata;
      logic [3:0]                  wstrb;
      logic                        w_full;
      logic [`CCV_NCH-1:0][2:0]    pin_action_select;
      logic [`CCV_NCH-1:0]         channel_irq_enable;
      logic [`CCV_NCH-1:0]         out_bit;
      logic [`CCV_NCH-1:0]         cap_overflow;
      logic [`CCV_NCH-1:0]         channel_irq_flag;
      logic [`CCV_NCH-1:0]         lvl_s1;
      logic [`CCV_NCH-1:0]         channel_input_level;
      logic [`CCV_NCH-1:0]         pin;
      logic                        counter_wrap_flag;
      logic                        wrap_irq_enable;
      logic [`CCV_NSTS-1:0]        sts;
      logic [`CCV_NSTS-1:0]        en;
      logic                        timer_irq;
      logic                        irq;
   } ccv_state_type;

endpackage

// File: design/ccv_out_action.sv
// Purpose: Next level of one channel output from its action mode and timer events
// Assumes: equ_x is the channel compare hit, equ_0 the period hit, both one-cycle pulses
// Notes:   Purely combinational; the caller registers the result
`timescale 1ns/1ps
module ccv_out_action (
   input  wire ccv_pkg::ccv_mode_type mode,       // Output action mode
   input  wire logic                  out_bit,    // Direct output level bit
   input  wire logic                  level,      // Present output level
   input  wire logic                  equ_x,      // Channel compare hit
   input  wire logic                  equ_0,      // Period hit
   output      logic                  next_level  // Level for the next cycle
);

   always_comb begin
      next_level = level;
      case (mode)
         ccv_pkg::CCV_MODE_DIRECT: begin
            next_level = out_bit;
         end
         ccv_pkg::CCV_MODE_SET: begin
            if (equ_x) next_level = 1'b1;
         end
         ccv_pkg::CCV_MODE_TOG_RESET: begin
            // Compare action wins when both events land together
            if (equ_x) next_level = ~level;
            else if (equ_0) next_level = 1'b0;
         end
         ccv_pkg::CCV_MODE_SET_RESET: begin
            if (equ_x) next_level = 1'b1;
            else if (equ_0) next_level = 1'b0;
         end
         ccv_pkg::CCV_MODE_TOGGLE: begin
            if (equ_x) next_level = ~level;
         end
         ccv_pkg::CCV_MODE_RESET: begin
            if (equ_x) next_level = 1'b0;
         end
         ccv_pkg::CCV_MODE_TOG_SET: begin
            if (equ_x) next_level = ~level;
            else if (equ_0) next_level = 1'b1;
         end
         ccv_pkg::CCV_MODE_RESET_SET: begin
            if (equ_x) next_level = 1'b0;
            else if (equ_0) next_level = 1'b1;
         end
         default: begin
            next_level = level;
         end
      endcase
   end

endmodule

// File: design/ccv_top.sv
// Purpose: Capture/compare channel control fields and pending source vector, AXI4-Lite slave
// Assumes: Timer events arrive on aclk as one-cycle pulses; channel inputs are asynchronous pins
// Notes:   Every output is registered; hardware sets beat same-cycle clears
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "ccv_map.svh"
module ccv_top (
   input  wire logic                    aclk,         // 50 MHz clock
   input  wire logic                    aresetn,      // Synchronous reset, active low
   input  wire ccv_pkg::ccv_axi_req_type axi_req,     // AXI4-Lite master to slave
   output      ccv_pkg::ccv_axi_rsp_type axi_rsp,     // AXI4-Lite slave to master
   input  wire ccv_pkg::ccv_event_type  timer_ev,     // Timer events and channel inputs
   output      logic [`CCV_NCH-1:0]     channel_out,  // Channel output pins
   output      logic                    timer_irq,    // Vector interrupt request
   output      logic                    irq           // Enabled event status interrupt
);

   ccv_pkg::ccv_state_type st;
   ccv_pkg::ccv_state_type next_st;
   logic [`CCV_NCH-1:0]    act_level;

   // True for every offset that holds a register
   function automatic logic is_mapped(input logic [`CCV_AW-1:0] a);
      logic hit;
      hit = 1'b0;
      if (a[1:0] == 2'h0) begin
         if (a < (`CCV_OFF_CTL0 + 8'(4 * `CCV_NCH))) hit = 1'b1;
         if (a == `CCV_OFF_VEC || a == `CCV_OFF_STS || a == `CCV_OFF_CLR) hit = 1'b1;
         if (a == `CCV_OFF_EN || a == `CCV_OFF_WRAP) hit = 1'b1;
      end
      return hit;
   endfunction

   // Channel index of a control register offset
   function automatic logic [2:0] chan_of(input logic [`CCV_AW-1:0] a);
      logic [`CCV_AW-1:0] rel;
      rel = a - `CCV_OFF_CTL0;
      return rel[4:2];
   endfunction

   // Lowest pending channel wins; the wrap flag comes last
   function automatic logic [15:0] vec_code(input logic [`CCV_NCH-1:0] pend,
                                            input logic wrap_pend);
      logic [15:0] code;
      code = `CCV_VEC_NONE;
      if (wrap_pend) code = `CCV_VEC_WRAP;
      for (int i = `CCV_NCH - 1; i >= 0; i--) begin
         if (pend[i]) code = 16'({4'(i + 1), 1'b0});
      end
      return code;
   endfunction

   genvar g;
   generate
      for (g = 0; g < `CCV_NCH; g++) begin : g_act
         ccv_out_action u_act (
            .mode       (ccv_pkg::ccv_mode_type'(st.pin_action_select[g])),
            .out_bit    (st.out_bit[g]),
            .level      (st.pin[g]),
            .equ_x      (timer_ev.compare_hit[g]),
            .equ_0      (timer_ev.period_hit),
            .next_level (act_level[g])
         );
      end
   endgenerate

   always_comb begin
      logic                do_write;
      logic [2:0]          wch;
      logic [2:0]          rch;
      logic [7:0]          wb;
      logic [`CCV_NCH-1:0] pend;
      logic [15:0]         code;
      logic [`CCV_NSTS-1:0] ev_sts;
      do_write = 1'b0;
      wch      = 3'h0;
      rch      = 3'h0;
      wb       = 8'h00;
      pend     = '0;
      code     = 16'h0000;
      ev_sts   = '0;
      next_st  = st;

      // Address and data are taken independently, in either order
      if (axi_req.awvalid && st.rsp.awready) begin
         next_st.awaddr  = axi_req.awaddr;
         next_st.aw_full = 1'b1;
      end
      if (axi_req.wvalid && st.rsp.wready) begin
         next_st.wdata  = axi_req.wdata;
         next_st.wstrb  = axi_req.wstrb;
         next_st.w_full = 1'b1;
      end
      if (st.rsp.bvalid && axi_req.bready) next_st.rsp.bvalid = 1'b0;

      // Software write; hardware sets below override a same-cycle clear
      do_write = st.aw_full && st.w_full && !st.rsp.bvalid;
      if (do_write) begin
         next_st.aw_full    = 1'b0;
         next_st.w_full     = 1'b0;
         next_st.rsp.bvalid = 1'b1;
         next_st.rsp.bresp  = is_mapped(st.awaddr) ? `CCV_RESP_OKAY : `CCV_RESP_SLV;
         wb  = st.wdata[7:0];
         wch = chan_of(st.awaddr);
         if (is_mapped(st.awaddr) && st.wstrb[0]) begin
            if (st.awaddr < `CCV_OFF_VEC) begin
               next_st.pin_action_select[wch]  = wb[`CCV_B_MODE +: 3];
               next_st.channel_irq_enable[wch] = wb[`CCV_B_IE];
               next_st.out_bit[wch]            = wb[`CCV_B_OUT];
               next_st.cap_overflow[wch]       = wb[`CCV_B_COV];
               next_st.channel_irq_flag[wch]   = wb[`CCV_B_FLAG];
            end else if (st.awaddr == `CCV_OFF_CLR) begin
               next_st.sts = st.sts & ~wb;
            end else if (st.awaddr == `CCV_OFF_EN) begin
               next_st.en = wb;
            end else if (st.awaddr == `CCV_OFF_WRAP) begin
               next_st.counter_wrap_flag = wb[`CCV_B_WRAP_FL];
               next_st.wrap_irq_enable   = wb[`CCV_B_WRAP_IE];
            end
         end
      end

      // Read: data is registered one cycle after the address is taken
      pend = st.channel_irq_flag & st.channel_irq_enable;
      code = vec_code(pend, st.counter_wrap_flag && st.wrap_irq_enable);
      if (st.rsp.rvalid && axi_req.rready) begin
         next_st.rsp.rvalid = 1'b0;
      end
      if (axi_req.arvalid && st.rsp.arready) begin
         next_st.rsp.rvalid = 1'b1;
         next_st.rsp.rdata  = '0;
         next_st.rsp.rresp  = is_mapped(axi_req.araddr) ? `CCV_RESP_OKAY : `CCV_RESP_SLV;
         rch = chan_of(axi_req.araddr);
         if (!is_mapped(axi_req.araddr)) begin
            next_st.rsp.rdata = '0;
         end else if (axi_req.araddr < `CCV_OFF_VEC) begin
            next_st.rsp.rdata[`CCV_B_MODE +: 3] = st.pin_action_select[rch];
            next_st.rsp.rdata[`CCV_B_IE]   = st.channel_irq_enable[rch];
            next_st.rsp.rdata[`CCV_B_LVL]  = st.channel_input_level[rch];
            next_st.rsp.rdata[`CCV_B_OUT]  = st.out_bit[rch];
            next_st.rsp.rdata[`CCV_B_COV]  = st.cap_overflow[rch];
            next_st.rsp.rdata[`CCV_B_FLAG] = st.channel_irq_flag[rch];
         end else if (axi_req.araddr == `CCV_OFF_VEC) begin
            next_st.rsp.rdata[15:0] = code;
            // Reading the vector acknowledges the source it reports
            if (code == `CCV_VEC_WRAP) begin
               next_st.counter_wrap_flag = 1'b0;
            end else if (code != `CCV_VEC_NONE) begin
               next_st.channel_irq_flag[3'(code[4:1] - 4'h1)] = 1'b0;
            end
         end else if (axi_req.araddr == `CCV_OFF_STS) begin
            next_st.rsp.rdata[`CCV_NSTS-1:0] = st.sts;
         end else if (axi_req.araddr == `CCV_OFF_EN) begin
            next_st.rsp.rdata[`CCV_NSTS-1:0] = st.en;
         end else if (axi_req.araddr == `CCV_OFF_WRAP) begin
            next_st.rsp.rdata[`CCV_B_WRAP_FL] = st.counter_wrap_flag;
            next_st.rsp.rdata[`CCV_B_WRAP_IE] = st.wrap_irq_enable;
         end
      end

      // Hardware events, applied last so a set beats a same-cycle clear
      for (int i = 0; i < `CCV_NCH; i++) begin
         if (timer_ev.capture_hit[i] && st.channel_irq_flag[i]) begin
            next_st.cap_overflow[i] = 1'b1;
            ev_sts[`CCV_STS_COV]    = 1'b1;
         end
         if (timer_ev.capture_hit[i] || timer_ev.compare_hit[i]) begin
            next_st.channel_irq_flag[i] = 1'b1;
            ev_sts[i]                   = 1'b1;
         end
      end
      if (timer_ev.counter_wrap) begin
         next_st.counter_wrap_flag = 1'b1;
         ev_sts[`CCV_STS_WRAP]     = 1'b1;
      end
      next_st.sts = next_st.sts | ev_sts;

      // Channel input level: two flops before anything reads it
      next_st.lvl_s1              = timer_ev.channel_input;
      next_st.channel_input_level = st.lvl_s1;
      next_st.pin                 = act_level;

      next_st.rsp.awready = !next_st.aw_full;
      next_st.rsp.wready  = !next_st.w_full;
      next_st.rsp.arready = !next_st.rsp.rvalid;
      next_st.timer_irq   = |(next_st.channel_irq_flag & next_st.channel_irq_enable)
                            || (next_st.counter_wrap_flag && next_st.wrap_irq_enable);
      next_st.irq         = |(next_st.sts & next_st.en);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign axi_rsp     = st.rsp;
   assign channel_out = st.pin;
   assign timer_irq   = st.timer_irq;
   assign irq         = st.irq;

endmodule

// File: tb/ccv_top_props.sv
// Purpose: Port-level assertions for the capture/compare control block
// Assumes: Bound to ccv_top; one clock domain
// Notes:   Read address is tracked so the answer can be judged later
`timescale 1ns/1ps
`include "ccv_map.svh"
module ccv_props (
   input wire logic                     aclk,        // Clock
   input wire logic                     aresetn,     // Reset, active low
   input wire ccv_pkg::ccv_axi_req_type axi_req,     // Bus request
   input wire ccv_pkg::ccv_axi_rsp_type axi_rsp,     // Bus answer
   input wire ccv_pkg::ccv_event_type   timer_ev,    // Timer events
   input wire logic [`CCV_NCH-1:0]      channel_out, // Channel pins
   input wire logic                     timer_irq,   // Vector request
   input wire logic                     irq          // Status request
);
   logic [7:0] rd_addr;
   logic       ev_any;
   logic       ev_pin;
   assign ev_any = |{timer_ev.compare_hit, timer_ev.capture_hit, timer_ev.counter_wrap};
   assign ev_pin = |timer_ev.compare_hit || timer_ev.period_hit;
   always_ff @(posedge aclk) begin
      if (axi_req.arvalid && axi_rsp.arready) begin
         rd_addr <= axi_req.araddr;
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
      else $error("read not answered next cycle");
   a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
      && axi_rsp.wready |-> ##2 axi_rsp.bvalid) else $error("write response late");
   a_vector_code: assert property (axi_rsp.rvalid && rd_addr == `CCV_OFF_VEC
      |-> axi_rsp.rdata[31:4] == 28'h0 && !axi_rsp.rdata[0]) else $error("vector code odd");
   a_unmapped_read: assert property (axi_req.arvalid && axi_rsp.arready && axi_req.araddr > 8'h33
      |=> axi_rsp.rresp == `CCV_RESP_SLV && axi_rsp.rdata == 32'h0) else $error("bad read ok");
   a_pin_cause: assert property ($changed(channel_out)
      |-> axi_rsp.bvalid || $past(axi_rsp.bvalid) || $past(ev_pin)) else $error("pin moved");
   a_req_rise: assert property ($rose(timer_irq)
      |-> axi_rsp.bvalid || $past(ev_any)) else $error("request rose without cause");
   a_req_fall: assert property ($fell(timer_irq)
      |-> axi_rsp.bvalid || axi_rsp.rvalid) else $error("request fell without access");
   a_irq_rise: assert property ($rose(irq) |-> axi_rsp.bvalid || $past(ev_any))
      else $error("irq rose without cause");
   a_irq_fall: assert property ($fell(irq) |-> axi_rsp.bvalid) else $error("irq fell alone");
   c_vector: cover property (axi_rsp.rvalid && rd_addr == `CCV_OFF_VEC && axi_rsp.rdata != 0);
   c_irq: cover property ($rose(irq));
   c_pin: cover property ($changed(channel_out));
endmodule
bind ccv_top ccv_props u_props (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
   .axi_rsp(axi_rsp), .timer_ev(timer_ev), .channel_out(channel_out),
   .timer_irq(timer_irq), .irq(irq));

// File: tb/test_capture_compare_ctl_and_vector.sv
// Purpose: Self-checking bench for the capture/compare control block
// Assumes: Bus tasks keep one transfer in flight and hold ready high
// Notes:   Expected values come from the register layout, never the design
`timescale 1ns/1ps
`include "ccv_map.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin mismatches++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module test_capture_compare_ctl_and_vector;
   logic                     aclk;
   logic                     aresetn;
   ccv_pkg::ccv_axi_req_type req;
   ccv_pkg::ccv_axi_rsp_type rsp;
   ccv_pkg::ccv_event_type   ev;
   logic [`CCV_NCH-1:0]      chout;
   logic                     tirq;
   logic                     irq;
   int                       mismatches;
   int                       checks;
   int                       cycles;
   logic [31:0]              d;
   logic [1:0]               r;
   ccv_top dut_u (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
      .timer_ev(ev), .channel_out(chout), .timer_irq(tirq), .irq(irq));
   always #10 aclk = ~aclk;
   // Ceiling well above the few hundred cycles the tests need
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic settle();
      repeat (2) @(posedge aclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      req.awaddr <= a;
      req.awvalid <= 1'b1;
      req.wdata <= v;
      req.wstrb <= 4'hF;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
      req.bready <= 1'b0;
      r = rsp.bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      req.rready <= 1'b0;
      d = rsp.rdata;
      r = rsp.rresp;
   endtask
   // One-cycle event pulse; outputs are sampled once its edge has landed
   task automatic pulse(input logic [5:0] cmp, input logic [5:0] cpt, input logic per,
                        input logic wrp);
      @(posedge aclk);
      ev <= '{cmp, cpt, ev.channel_input, per, wrp};
      @(posedge aclk);
      ev <= '{6'h0, 6'h0, ev.channel_input, 1'b0, 1'b0};
      #1;
   endtask
   task automatic t_reset();
      `CHK("pins at reset", 8'h0, {chout, tirq, irq})
      rd(`CCV_OFF_VEC);
      `CHK("vector at reset", 32'h0, d)
      rd(`CCV_OFF_CTL0);
      `CHK("control at reset", 32'h0, d)
      rd(8'h40);
      `CHK("unmapped read resp", `CCV_RESP_SLV, r)
      wr(8'h41, 32'hFF);
      `CHK("misaligned write resp", `CCV_RESP_SLV, r)
      $display("test t_reset done");
   endtask
   task automatic t_input();
      logic [5:0] lv;
      lv = 6'h2A;
      @(posedge aclk);
      ev.channel_input <= lv;
      // Writing 1 to the level bit must not stick
      for (int n = 0; n < 6; n++) begin
         wr(8'(4 * n), 32'h08);
         rd(8'(4 * n));
         `CHK("input level bit", {28'h0, lv[n], 3'h0}, d)
      end
      $display("test t_input done");
   endtask
   task automatic t_modes();
      logic [7:0] on_cmp;
      logic [7:0] on_per;
      on_cmp = 8'h5E;
      on_per = 8'hD2;
      for (int v = 0; v < 2; v++) begin
         wr(`CCV_OFF_CTL0, 32'(v << 2));
         settle();
         `CHK("direct output", 1'(v), chout[0])
      end
      for (int m = 1; m < 8; m++) begin
         wr(`CCV_OFF_CTL0, 32'h0);
         wr(`CCV_OFF_CTL0, 32'(m << 5));
         pulse(6'h01, 6'h0, 1'b0, 1'b0);
         `CHK("level after compare", on_cmp[m], chout[0])
         pulse(6'h0, 6'h0, 1'b1, 1'b0);
         `CHK("level after period", on_per[m], chout[0])
      end
      $display("test t_modes done");
   endtask
   task automatic t_vector();
      logic [15:0] exp [4];
      exp = '{16'h0002, 16'h0008, `CCV_VEC_WRAP, `CCV_VEC_NONE};
      wr(`CCV_OFF_CTL0, 32'h10);
      wr(8'h0C, 32'h10);
      wr(`CCV_OFF_WRAP, 32'h02);
      pulse(6'h0F, 6'h0, 1'b0, 1'b1);
      `CHK("request raised", 1'b1, tirq)
      foreach (exp[i]) begin
         rd(`CCV_OFF_VEC);
         `CHK("vector code", {16'h0, exp[i]}, d)
      end
      settle();
      `CHK("request after drain", 1'b0, tirq)
      rd(8'h04);
      `CHK("disabled flag kept", 1'b1, d[0])
      $display("test t_vector done");
   endtask
   task automatic t_overflow();
      wr(8'h10, 32'h10);
      pulse(6'h0, 6'h10, 1'b0, 1'b0);
      pulse(6'h0, 6'h10, 1'b0, 1'b0);
      rd(8'h10);
      `CHK("overflow set", 32'h13, d)
      rd(`CCV_OFF_VEC);
      `CHK("vector channel five", 32'h0A, d)
      pulse(6'h10, 6'h0, 1'b0, 1'b0);
      rd(8'h10);
      `CHK("overflow kept", 32'h13, d)
      wr(8'h10, 32'h11);
      rd(8'h10);
      `CHK("overflow cleared", 32'h11, d)
      $display("test t_overflow done");
   endtask
   task automatic t_status();
      wr(`CCV_OFF_CLR, 32'hFF);
      rd(`CCV_OFF_STS);
      `CHK("status cleared", 32'h0, d)
      wr(`CCV_OFF_EN, 32'h40);
      pulse(6'h0, 6'h0, 1'b0, 1'b1);
      `CHK("irq raised", 1'b1, irq)
      wr(`CCV_OFF_STS, 32'h0);
      `CHK("status write resp", `CCV_RESP_OKAY, r)
      rd(`CCV_OFF_STS);
      `CHK("status wrap bit", 32'h40, d)
      wr(`CCV_OFF_EN, 32'h0);
      settle();
      `CHK("irq masked", 1'b0, irq)
      wr(`CCV_OFF_EN, 32'h40);
      settle();
      `CHK("irq unmasked", 1'b1, irq)
      wr(`CCV_OFF_CLR, 32'h40);
      settle();
      `CHK("irq cleared", 1'b0, irq)
      rd(`CCV_OFF_CLR);
      `CHK("clear reads zero", 32'h0, d)
      $display("test t_status done");
   endtask
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      req = '0;
      ev = '0;
      mismatches = 0;
      checks = 0;
      cycles = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_input();
      t_modes();
      t_vector();
      t_overflow();
      t_status();
      close_out();
   end
endmodule
